/* pkg/core_pipe_pkg.sv */
package core_pipe_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Phases of one instruction cycle, index 0 is the first
   localparam logic [1:0]  phase_q1    = 2'h0;
   localparam logic [1:0]  phase_q2    = 2'h1;
   localparam logic [1:0]  phase_q3    = 2'h2;
   localparam logic [1:0]  phase_q4    = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and steps
   localparam logic [20:0] pc_reset    = 21'h000000;
   localparam logic [20:0] pc_step     = 21'h000002;
   localparam logic [15:0] nop_word    = 16'h0000;
   localparam logic [7:0]  byte_reset  = 8'h00;
   localparam logic [11:0] ptr_reset   = 12'h000;

   ////////////////////////////////////////////////////////////////////////
   // Core register addresses in data space
   localparam logic [11:0] addr_pc_upper_latch = 12'hffb;
   localparam logic [11:0] addr_pc_high_latch  = 12'hffa;
   localparam logic [11:0] addr_pc_low_byte    = 12'hff9;
   localparam logic [11:0] addr_table_ptr_u    = 12'hff8;
   localparam logic [11:0] addr_table_ptr_h    = 12'hff7;
   localparam logic [11:0] addr_table_ptr_l    = 12'hff6;
   localparam logic [11:0] addr_table_latch    = 12'hff5;
   localparam logic [11:0] addr_bank_select    = 12'hfe0;
   localparam logic [11:0] addr_indirect0      = 12'hfef;
   localparam logic [11:0] addr_indirect1      = 12'hfe7;
   localparam logic [11:0] addr_indirect2      = 12'hfdf;
   localparam logic [11:0] addr_ptr0_high      = 12'hfea;
   localparam logic [11:0] addr_ptr0_low       = 12'hfe9;
   localparam logic [11:0] addr_ptr1_high      = 12'hfe2;
   localparam logic [11:0] addr_ptr1_low       = 12'hfe1;
   localparam logic [11:0] addr_ptr2_high      = 12'hfda;
   localparam logic [11:0] addr_ptr2_low       = 12'hfd9;
   localparam logic [3:0]  access_low_bank     = 4'h0;
   localparam logic [3:0]  access_high_bank    = 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // Opcode patterns: value and mask
   localparam logic [15:0] op_movlw_v  = 16'h0e00, op_movlw_m  = 16'hff00;
   localparam logic [15:0] op_return_with_literal_v  = 16'h0c00, op_return_with_literal_m  = 16'hff00;
   localparam logic [15:0] op_movlb_v  = 16'h0010, op_movlb_m  = 16'hfff0;
   localparam logic [15:0] op_tblrd_v  = 16'h0008, op_tblwt_v  = 16'h000c;
   localparam logic [15:0] op_exact_m  = 16'hffff;
   localparam logic [15:0] op_movwf_v  = 16'h6e00, op_movwf_m  = 16'hfe00;
   localparam logic [15:0] op_tstfsz_v = 16'h6600, op_tstfsz_m = 16'hfe00;
   localparam logic [15:0] op_add_working_to_location_v  = 16'h2400, op_add_working_to_location_m  = 16'hfc00;
   localparam logic [15:0] op_movf_v   = 16'h5000, op_movf_m   = 16'hfc00;
   localparam logic [15:0] op_bra_v    = 16'hd000, op_bra_m    = 16'hf800;
   localparam logic [15:0] op_goto_v   = 16'hef00, op_goto_m   = 16'hff00;
   localparam logic [15:0] op_call_v   = 16'hec00, op_call_m   = 16'hfe00;
   localparam logic [15:0] op_load_indirect_pointer_v   = 16'hee00, op_load_indirect_pointer_m   = 16'hffc0;
   localparam logic [15:0] op_register_to_register_move_v  = 16'hc000, op_register_to_register_move_m  = 16'hf000;
   localparam logic [15:0] op_second_v = 16'hf000, op_second_m = 16'hf000;

   typedef enum logic {run_first, run_second} exec_state_type;

   function automatic logic op_is(input logic [15:0] w,
                                  input logic [15:0] v,
                                  input logic [15:0] m);
      return (w & m) == v;
   endfunction : op_is

   function automatic logic is_two_word(input logic [15:0] w);
      return op_is(w, op_register_to_register_move_v, op_register_to_register_move_m) | op_is(w, op_goto_v, op_goto_m)
           | op_is(w, op_call_v, op_call_m) | op_is(w, op_load_indirect_pointer_v, op_load_indirect_pointer_m);
   endfunction : is_two_word

endpackage : core_pipe_pkg

/* logic/data_address_resolver.sv */
`timescale 1ns/10ps
`default_nettype none
module data_address_resolver
   import core_pipe_pkg::*;
#(
   parameter logic [7:0] access_split = 8'h80
)(
   // Operand fields
   input  wire logic [7:0]       direct_f,
   input  wire logic             use_bank,
   input  wire logic             full_sel,
   input  wire logic [11:0]      full_addr,
   // Banking state
   input  wire logic [3:0]       bank,
   input  wire logic [2:0][11:0] pointers,
   // Resolved address
   output logic      [11:0]      addr
);

   logic [11:0] bank_addr;
   logic [11:0] access_addr;
   logic [11:0] raw_addr;

   assign bank_addr   = {bank, direct_f};
   // Low part of bank 0 and high part of bank 15, no bank select
   assign access_addr = (direct_f < access_split)
                        ? {access_low_bank, direct_f}
                        : {access_high_bank, direct_f};
   assign raw_addr    = full_sel ? full_addr
                        : (use_bank ? bank_addr : access_addr);
   // Indirect slots swap in a full pointer, ignoring the bank
   assign addr = (raw_addr == addr_indirect0) ? pointers[0]
               : (raw_addr == addr_indirect1) ? pointers[1]
               : (raw_addr == addr_indirect2) ? pointers[2]
               : raw_addr;

endmodule : data_address_resolver
`default_nettype wire

/* logic/core_fetch_pipeline.sv */
`timescale 1ns/10ps
`default_nettype none
module core_fetch_pipeline
   import core_pipe_pkg::*;
#(
   parameter logic [11:0] gpr_last     = 12'h5ff,
   parameter logic [11:0] sfr_first    = 12'hf00,
   parameter logic [7:0]  access_split = 8'h80
)(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Program fetch
   output logic      [20:0] prog_addr,
   input  wire logic [15:0] prog_rdata,
   // Data memory
   output logic      [11:0] data_addr,
   output logic             data_rd,
   output logic             data_wr,
   output logic      [7:0]  data_wdata,
   input  wire logic [7:0]  data_rdata,
   // Table transfers
   output logic      [20:0] tbl_addr,
   output logic             tbl_rd,
   output logic             tbl_wr,
   output logic      [7:0]  tbl_wdata,
   input  wire logic [15:0] tbl_rdata,
   // Core state
   output logic      [7:0]  working_register,
   output logic      [3:0]  bank_select_register,
   output logic      [1:0]  phase
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [1:0]       phase_q;
   logic [20:0]      pc_q;
   logic [20:0]      ret_q;
   logic [15:0]      ir_q;
   logic [15:0]      first_q;
   exec_state_type   state_q;
   logic             kill_q;
   logic [7:0]       working_q;
   logic [7:0]       pc_high_latch_q;
   logic [4:0]       pc_upper_latch_q;
   logic [3:0]       bsr_q;
   logic [2:0][11:0] fsr_q;
   logic [20:0]      table_ptr_q;
   logic [7:0]       table_latch_q;
   logic [7:0]       operand_q;
   logic [7:0]       result_q;
   logic             wr_pend_q;
   logic             dest_w_q;
   logic [20:0]      prog_addr_q;
   logic [11:0]      data_addr_q;
   logic             data_rd_q;
   logic             data_wr_q;
   logic [7:0]       data_wdata_q;
   logic [20:0]      tbl_addr_q;
   logic             tbl_rd_q;
   logic             tbl_wr_q;
   logic [7:0]       tbl_wdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   logic        first_live;
   logic        in_second;
   logic        do_movlw, do_return_with_literal, do_movlb, do_tblrd, do_tblwt;
   logic        do_movwf, do_tstfsz, do_add_working_to_location, do_movf, do_bra;
   logic        do_movff1, do_two1;
   logic        do_goto2, do_call2, do_lfsr2, do_movff2;
   logic        dest_f;
   logic        need_read;
   logic        wr_f;
   logic        wr_w;

   // A killed slot or a lone second word runs as a full empty cycle
   assign first_live = (state_q == run_first) && !kill_q
                       && !op_is(ir_q, op_second_v, op_second_m);
   assign in_second  = (state_q == run_second);
   assign dest_f     = ir_q[9];
   assign do_movlw   = first_live && op_is(ir_q, op_movlw_v, op_movlw_m);
   assign do_return_with_literal   = first_live && op_is(ir_q, op_return_with_literal_v, op_return_with_literal_m);
   assign do_movlb   = first_live && op_is(ir_q, op_movlb_v, op_movlb_m);
   assign do_tblrd   = first_live && op_is(ir_q, op_tblrd_v, op_exact_m);
   assign do_tblwt   = first_live && op_is(ir_q, op_tblwt_v, op_exact_m);
   assign do_movwf   = first_live && op_is(ir_q, op_movwf_v, op_movwf_m);
   assign do_tstfsz  = first_live && op_is(ir_q, op_tstfsz_v, op_tstfsz_m);
   assign do_add_working_to_location   = first_live && op_is(ir_q, op_add_working_to_location_v, op_add_working_to_location_m);
   assign do_movf    = first_live && op_is(ir_q, op_movf_v, op_movf_m);
   assign do_bra     = first_live && op_is(ir_q, op_bra_v, op_bra_m);
   assign do_movff1  = first_live && op_is(ir_q, op_register_to_register_move_v, op_register_to_register_move_m);
   assign do_two1    = first_live && is_two_word(ir_q);
   assign do_goto2   = in_second && op_is(first_q, op_goto_v, op_goto_m);
   assign do_call2   = in_second && op_is(first_q, op_call_v, op_call_m);
   assign do_lfsr2   = in_second && op_is(first_q, op_load_indirect_pointer_v, op_load_indirect_pointer_m);
   assign do_movff2  = in_second && op_is(first_q, op_register_to_register_move_v, op_register_to_register_move_m);
   assign need_read  = do_movf | do_add_working_to_location | do_tstfsz | do_movff1;
   assign wr_f       = ((do_add_working_to_location | do_movf) & dest_f) | do_movwf | do_movff2;
   assign wr_w       = (do_add_working_to_location | do_movf) & !dest_f;

   ////////////////////////////////////////////////////////////////////////
   // Data address and operand read
   logic [11:0] res_addr;
   logic [20:0] next_pc;
   logic        core_hit;
   logic [7:0]  core_val;
   logic        ext_impl;
   logic [7:0]  operand_v;
   logic [7:0]  alu_v;

   data_address_resolver #(
      .access_split (access_split)
   ) u_resolver (
      .direct_f  (ir_q[7:0]),
      .use_bank  (ir_q[8]),
      .full_sel  (do_movff1 | in_second),   // first or second word low 12 bits
      .full_addr (ir_q[11:0]),
      .bank      (bsr_q),
      .pointers  (fsr_q),
      .addr      (res_addr)
   );

   // Counter runs two words ahead of the word being executed
   assign next_pc = pc_q - pc_step;

   always_comb begin
      core_hit = 1'b1;
      case (res_addr)
         addr_pc_low_byte:    core_val = next_pc[7:0];
         addr_pc_high_latch:  core_val = pc_high_latch_q;
         addr_pc_upper_latch: core_val = {3'h0, pc_upper_latch_q};
         addr_table_ptr_l:    core_val = table_ptr_q[7:0];
         addr_table_ptr_h:    core_val = table_ptr_q[15:8];
         addr_table_ptr_u:    core_val = {3'h0, table_ptr_q[20:16]};
         addr_table_latch:    core_val = table_latch_q;
         addr_bank_select:    core_val = {4'h0, bsr_q};
         addr_ptr0_low:       core_val = fsr_q[0][7:0];
         addr_ptr0_high:      core_val = {4'h0, fsr_q[0][11:8]};
         addr_ptr1_low:       core_val = fsr_q[1][7:0];
         addr_ptr1_high:      core_val = {4'h0, fsr_q[1][11:8]};
         addr_ptr2_low:       core_val = fsr_q[2][7:0];
         addr_ptr2_high:      core_val = {4'h0, fsr_q[2][11:8]};
         default: begin
            core_hit = 1'b0;
            core_val = byte_reset;
         end
      endcase
   end

   // General registers grow up from zero, special ones down from the top
   assign ext_impl  = (res_addr <= gpr_last) || (res_addr >= sfr_first);
   assign operand_v = core_hit ? core_val
                    : (ext_impl ? data_rdata : byte_reset);
   assign alu_v     = do_add_working_to_location  ? working_q + operand_v
                    : do_movwf  ? working_q
                    : do_movff2 ? operand_q
                    : operand_v;

   ////////////////////////////////////////////////////////////////////////
   // Branch resolution at the end of the fourth phase
   logic        pcl_wr;
   logic        jump_now;
   logic        skip_now;
   logic [20:0] bra_tgt;
   logic [20:0] abs_tgt;
   logic [20:0] pcl_tgt;
   logic [20:0] jump_tgt;

   assign pcl_wr   = wr_pend_q && (data_addr_q == addr_pc_low_byte);
   assign bra_tgt  = next_pc + {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
   assign abs_tgt  = {ir_q[11:0], first_q[7:0], 1'b0};
   // Latches feed the high bytes; bit 0 forced low
   assign pcl_tgt  = {pc_upper_latch_q, pc_high_latch_q,
                      result_q[7:1], 1'b0};
   assign jump_now = do_bra | do_goto2 | do_call2 | do_return_with_literal | pcl_wr;
   assign skip_now = do_tstfsz && (operand_q == byte_reset);
   assign jump_tgt = do_bra ? bra_tgt
                   : (do_goto2 | do_call2) ? abs_tgt
                   : do_return_with_literal ? ret_q
                   : pcl_tgt;

   ////////////////////////////////////////////////////////////////////////
   // Phase counter and pipeline
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         phase_q <= phase_q1;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pc_q        <= pc_reset;
         prog_addr_q <= pc_reset;
         ir_q        <= nop_word;
         first_q     <= nop_word;
         state_q     <= run_first;
         kill_q      <= 1'b0;
         ret_q       <= pc_reset;
      end else if (phase_q == phase_q1) begin
         prog_addr_q <= pc_q;
         pc_q        <= pc_q + pc_step;
      end else if (phase_q == phase_q4) begin
         ir_q    <= prog_rdata;
         // Word already fetched behind a branch is discarded
         kill_q  <= jump_now | skip_now;
         state_q <= do_two1 ? run_second : run_first;
         if (do_two1) begin
            first_q <= ir_q;
         end
         if (do_call2) begin
            ret_q <= next_pc;
         end
         if (jump_now) begin
            pc_q <= jump_tgt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus strobes: data read and both table strobes in the second phase, data write in the fourth
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         data_addr_q  <= ptr_reset;
         data_rd_q    <= 1'b0;
         data_wr_q    <= 1'b0;
         data_wdata_q <= byte_reset;
         tbl_addr_q   <= pc_reset;
         tbl_rd_q     <= 1'b0;
         tbl_wr_q     <= 1'b0;
         tbl_wdata_q  <= byte_reset;
      end else begin
         data_rd_q <= (phase_q == phase_q1) && need_read && !core_hit && ext_impl;
         data_wr_q <= (phase_q == phase_q3) && wr_f && !core_hit && ext_impl;
         tbl_rd_q  <= (phase_q == phase_q1) && do_tblrd;
         tbl_wr_q  <= (phase_q == phase_q1) && do_tblwt;
         if (phase_q == phase_q1 || phase_q == phase_q3) begin
            data_addr_q <= res_addr;
         end
         if (phase_q == phase_q3) begin
            data_wdata_q <= alu_v;
         end
         if (phase_q == phase_q1) begin
            tbl_addr_q  <= table_ptr_q;
            tbl_wdata_q <= table_latch_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand capture at the end of the third phase
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         operand_q <= byte_reset;
         result_q  <= byte_reset;
         wr_pend_q <= 1'b0;
         dest_w_q  <= 1'b0;
      end else if (phase_q == phase_q3) begin
         if (need_read) begin
            operand_q <= operand_v;
         end
         result_q  <= alu_v;
         wr_pend_q <= wr_f;
         dest_w_q  <= wr_w;
      end else if (phase_q == phase_q4) begin
         wr_pend_q <= 1'b0;
         dest_w_q  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core registers
   logic       core_wr;
   logic [1:0] load_indirect_pointer_idx;

   assign core_wr  = (phase_q == phase_q4) && wr_pend_q;
   assign load_indirect_pointer_idx = first_q[5:4];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         working_q        <= byte_reset;
         pc_high_latch_q  <= byte_reset;
         pc_upper_latch_q <= 5'h00;
         bsr_q            <= 4'h0;
         fsr_q            <= {3{ptr_reset}};
         table_ptr_q      <= pc_reset;
         table_latch_q    <= byte_reset;
      end else begin
         // A read of the low byte copies the high bytes; the add does not
         if (phase_q == phase_q3 && need_read && !do_add_working_to_location
             && res_addr == addr_pc_low_byte) begin
            pc_high_latch_q  <= next_pc[15:8];
            pc_upper_latch_q <= next_pc[20:16];
         end
         if (phase_q == phase_q3 && do_tblrd) begin
            table_latch_q <= table_ptr_q[0] ? tbl_rdata[15:8]
                                            : tbl_rdata[7:0];
         end
         if (phase_q == phase_q4) begin
            if (do_movlw || do_return_with_literal) begin
               working_q <= ir_q[7:0];
            end else if (dest_w_q) begin
               working_q <= result_q;
            end
            if (do_movlb) begin
               bsr_q <= ir_q[3:0];
            end
            if (do_lfsr2 && load_indirect_pointer_idx != 2'h3) begin
               fsr_q[load_indirect_pointer_idx] <= {first_q[3:0], ir_q[7:0]};
            end
         end
         if (core_wr) begin
            if (data_addr_q == addr_pc_high_latch) begin
               pc_high_latch_q <= result_q;
            end else if (data_addr_q == addr_pc_upper_latch) begin
               pc_upper_latch_q <= result_q[4:0];
            end else if (data_addr_q == addr_bank_select) begin
               bsr_q <= result_q[3:0];
            end else if (data_addr_q == addr_table_ptr_l) begin
               table_ptr_q[7:0] <= result_q;
            end else if (data_addr_q == addr_table_ptr_h) begin
               table_ptr_q[15:8] <= result_q;
            end else if (data_addr_q == addr_table_ptr_u) begin
               table_ptr_q[20:16] <= result_q[4:0];
            end else if (data_addr_q == addr_table_latch) begin
               table_latch_q <= result_q;
            end else if (data_addr_q == addr_ptr0_low) begin
               fsr_q[0][7:0] <= result_q;
            end else if (data_addr_q == addr_ptr0_high) begin
               fsr_q[0][11:8] <= result_q[3:0];
            end else if (data_addr_q == addr_ptr1_low) begin
               fsr_q[1][7:0] <= result_q;
            end else if (data_addr_q == addr_ptr1_high) begin
               fsr_q[1][11:8] <= result_q[3:0];
            end else if (data_addr_q == addr_ptr2_low) begin
               fsr_q[2][7:0] <= result_q;
            end else if (data_addr_q == addr_ptr2_high) begin
               fsr_q[2][11:8] <= result_q[3:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prog_addr            = prog_addr_q;
   assign data_addr            = data_addr_q;
   assign data_rd              = data_rd_q;
   assign data_wr              = data_wr_q;
   assign data_wdata           = data_wdata_q;
   assign tbl_addr             = tbl_addr_q;
   assign tbl_rd               = tbl_rd_q;
   assign tbl_wr               = tbl_wr_q;
   assign tbl_wdata            = tbl_wdata_q;
   assign working_register     = working_q;
   assign bank_select_register = bsr_q;
   assign phase                = phase_q;

endmodule : core_fetch_pipeline
`default_nettype wire

/* verification/core_fetch_pipeline_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module core_fetch_pipeline_sva
   import core_pipe_pkg::*;
#(
   parameter logic [11:0] gpr_last  = 12'h5ff,
   parameter logic [11:0] sfr_first = 12'hf00
)(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // Observed outputs
   input wire logic [20:0] prog_addr,
   input wire logic [11:0] data_addr,
   input wire logic        data_rd,
   input wire logic        data_wr,
   input wire logic        tbl_rd,
   input wire logic        tbl_wr,
   input wire logic [1:0]  phase
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   sequence s_walk;
      phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0;
   endsequence
   sequence s_rd_hold;
      !data_rd && $stable(data_addr);
   endsequence
   property p_walk; phase == 2'h1 |=> s_walk; endproperty
   property p_even; !prog_addr[0]; endproperty
   property p_fetch_hold; phase != 2'h1 |-> $stable(prog_addr); endproperty
   property p_rd_slot; data_rd |-> phase == 2'h1 ##1 s_rd_hold; endproperty
   property p_wr_slot; data_wr |-> phase == 2'h3 ##1 !data_wr; endproperty
   // Gap addresses must never reach the bus, they read as zero inside
   property p_impl;
      (data_rd || data_wr) |-> (data_addr <= gpr_last || data_addr >= sfr_first);
   endproperty
   property p_core_quiet;
      (data_rd || data_wr) |->
         data_addr != addr_pc_low_byte && data_addr != addr_bank_select;
   endproperty
   property p_tbl_slot; (tbl_rd || tbl_wr) |-> phase == 2'h1; endproperty
   ////////////////////////////////////////////////////////////////////////
   a_walk: assert property (p_walk) else $error("phase walk broken");
   a_even: assert property (p_even) else $error("odd fetch");
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved");
   a_rd_slot: assert property (p_rd_slot) else $error("read slot");
   a_wr_slot: assert property (p_wr_slot) else $error("write slot");
   a_impl: assert property (p_impl) else $error("gap strobed");
   a_core_quiet: assert property (p_core_quiet) else $error("core reg");
   a_tbl_slot: assert property (p_tbl_slot) else $error("table slot");
endmodule : core_fetch_pipeline_sva
bind core_fetch_pipeline core_fetch_pipeline_sva #(.gpr_last(gpr_last),
   .sfr_first(sfr_first)) chk_u (.clock(clock), .rst_b(rst_b),
   .prog_addr(prog_addr), .data_addr(data_addr), .data_rd(data_rd),
   .data_wr(data_wr), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .phase(phase));
`default_nettype wire

/* verification/prog_data_model.sv */
`timescale 1ns/10ps
`default_nettype none
module prog_data_model (
   // Clock
   input wire logic         clock,
   // Program and table side
   input wire logic  [20:0] prog_addr,
   output logic      [15:0] prog_rdata,
   input wire logic  [20:0] tbl_addr,
   input wire logic         tbl_rd,
   output logic      [15:0] tbl_rdata,
   // Data side
   input wire logic  [11:0] data_addr,
   input wire logic         data_rd,
   input wire logic         data_wr,
   input wire logic  [7:0]  data_wdata,
   output logic      [7:0]  data_rdata
);
   logic [15:0] prog [0:255];
   logic [7:0]  ram [0:4095];
   logic        rd_q, tbl_q;
   logic [11:0] a_q;
   logic [7:0]  t_q, junk_q;
   initial begin
      foreach (ram[i]) ram[i] = 8'h00;
      foreach (prog[i]) prog[i] = 16'h0000;
      junk_q = 8'h3c;
   end
   // Outside the answer slot the bus shows churn, never a held value
   always @(posedge clock) begin
      rd_q <= data_rd;
      tbl_q <= tbl_rd;
      a_q <= data_addr;
      t_q <= tbl_addr[8:1];
      junk_q <= junk_q + 8'h5b;
      if (data_wr) ram[data_addr] <= data_wdata;
   end
   assign prog_rdata = prog[prog_addr[8:1]];
   assign data_rdata = rd_q ? ram[a_q] : junk_q;
   assign tbl_rdata  = tbl_q ? prog[t_q] : {junk_q, ~junk_q};
endmodule : prog_data_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clock, rst_b, data_rd, data_wr, tbl_rd, tbl_wr;
   logic [20:0] prog_addr, tbl_addr;
   logic [15:0] prog_rdata, tbl_rdata;
   logic [11:0] data_addr;
   logic [7:0]  data_wdata, data_rdata, tbl_wdata, working_register, rnd;
   logic [3:0]  bank_select_register;
   logic [1:0]  phase;
   logic [19:0] exp_q[$];
   int          num_errors = 0;
   int          tests_run = 0;
   int          tbl_seen = 0;
   core_fetch_pipeline dut_u (.clock(clock), .rst_b(rst_b),
      .prog_addr(prog_addr), .prog_rdata(prog_rdata), .data_addr(data_addr),
      .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
      .data_rdata(data_rdata), .tbl_addr(tbl_addr), .tbl_rd(tbl_rd),
      .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
      .working_register(working_register),
      .bank_select_register(bank_select_register), .phase(phase));
   prog_data_model mem_u (.clock(clock), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .tbl_addr(tbl_addr), .tbl_rd(tbl_rd),
      .tbl_rdata(tbl_rdata), .data_addr(data_addr), .data_rd(data_rd),
      .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [19:0] seen,
                        input logic [19:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////
   // Every bus write must be the next one the reference program predicts
   // Sampled mid-cycle, away from the edge that moves the strobes
   always @(negedge clock) begin
      if (data_wr === 1'b1) begin
         if (exp_q.size() == 0) check("stray write", {data_addr, data_wdata}, 'x);
         else check("write", {data_addr, data_wdata}, exp_q.pop_front());
      end
      if (tbl_wr === 1'b1) begin
         tbl_seen++;
         check("table write", {tbl_addr[11:0], tbl_wdata}, 20'h0036e);
      end
   end
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      #4_000_000;
      num_errors++;
      finish_test();
   end
   initial begin
      // Skipped move at 0e, jump over 16/18, goto flushes 22; 18 returns 3c
      automatic logic [15:0] lo [0:17] = '{16'h0e55, 16'h6e10, 16'h0013,
         16'h6f20, 16'hc010, 16'hf456, 16'h6630, 16'hc010, 16'hf456,
         16'h0e05, 16'h26f9, 16'h6e11, 16'h0c3c, 16'h0e00, 16'h6e13,
         16'hef20, 16'hf000, 16'h6e14};
      // Pointer store, table read and write, call into 18, then spin at 60
      automatic logic [15:0] hi [0:17] = '{16'h0017, 16'h5100, 16'h6e15,
         16'hee01, 16'hf023, 16'h0ea5, 16'h6eef, 16'h0e03, 16'h6ef6,
         16'h0008, 16'h000c, 16'hcff5, 16'hf017, 16'hec0c, 16'hf000,
         16'h6e16, 16'hef30, 16'hf000};
      rst_b = 1'b0;
      void'($urandom(13));
      rnd = 8'($urandom);
      lo[13][7:0] = rnd;
      exp_q = '{{12'h010, 8'h55}, {12'h320, 8'h55}, {12'h456, 8'h55}};
      // Odd offset 5 from next word 16 must land on even word 1a
      exp_q.push_back({12'h013, rnd});
      exp_q.push_back({12'h015, 8'h00});
      exp_q.push_back({12'h123, 8'ha5});
      exp_q.push_back({12'h017, 8'h6e});
      exp_q.push_back({12'h016, 8'h3c});
      repeat (16) @(posedge clock);
      // The model clears its memory at time zero, so load only after that
      #1;
      foreach (lo[i]) mem_u.prog[i] = lo[i];
      foreach (hi[i]) mem_u.prog[32 + i] = hi[i];
      rst_b = 1'b1;
      for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clock);
      repeat (80) @(posedge clock);
      check("pending writes", 20'(exp_q.size()), 20'h00000);
      check("working", {12'h000, working_register}, 20'h0003c);
      check("table writes", 20'(tbl_seen), 20'h00001);
      check("bank", {16'h0000, bank_select_register}, 20'h00007);
      finish_test();
   end
endmodule : tb
`default_nettype wire
